// file: hdl/output_gain_offset_stage.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`include "out_stage_regs.svh"
module output_gain_offset_stage #(
  parameter int W = 18,
  parameter int NSTAGE = 4
) (
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave, word address
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // processed samples in
  input wire logic in_valid,
  input wire logic signed [W-1:0] in_a_i,
  input wire logic signed [W-1:0] in_a_q,
  input wire logic signed [W-1:0] in_b_i,
  input wire logic signed [W-1:0] in_b_q,
  // port a and port b to the converter
  output logic out_valid,
  output logic signed [W-1:0] out_a_i,
  output logic signed [W-1:0] out_a_q,
  output logic signed [W-1:0] out_b_i,
  output logic signed [W-1:0] out_b_q,
  output logic [11:0] latency_samples
);
  ////////////////////////////////////////////////////////////////////
  // registers
  // map, by word index on the bus:
  //   F3 port a gain, sign plus magnitude
  //   F4 port b gain, same coding
  //   F5 channel-0 i offset, also channel-0 real offset
  //   F6 channel-0 q offset
  //   F7 channel-1 i offset, also channel-1 real offset
  //   F8 channel-1 q offset
  //   F9 mode: bit 0 two-channel, bit 1 real output
  //   FA computed latency in whole samples, read only
  //   FB stage config: enables in bits 3:0, cancel delay above
  // every word sits in the low half of the bus, sixteen bits at most
  // the upper half of a write is dropped and reads back as zero
  // all writable words clear on reset, so both ports start out silent; FA reads the computed latency
  // software must load a non-zero gain before any sample leaves
  // the offsets may stay at zero, they only shift the dc level
  // mode and stage config are local additions for this stage
  // a write to FA or to an unused index changes nothing
  // a read of an unused index answers zero, never an error
  logic [15:0] port_a_gain_r;
  logic [15:0] port_b_gain_r;
  logic [15:0] chan0_i_dc_offset_r;
  logic [15:0] chan0_q_dc_offset_r;
  logic [15:0] chan1_i_dc_offset_r;
  logic [15:0] chan1_q_dc_offset_r;
  logic [1:0] mode_r;
  logic [15:0] stage_cfg_r;
  logic [11:0] latency_r;
  out_stage_pkg::bus_state_e bus_r;
  logic wr_hit;

  assign wr_hit = write && (bus_r == out_stage_pkg::BUS_IDLE);

  // bus handshake: one wait cycle, then the access completes
  // the slave looks at read and write only while idle
  // a request seen while idle moves to the answer state
  // the answer state lasts one cycle and always returns to idle
  // the master sees waitrequest low at the edge after acceptance
  // and drops its request at that same edge
  // a back-to-back request is therefore seen one edge later,
  // which keeps one access from being answered twice
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_r <= out_stage_pkg::BUS_IDLE;
    end else begin
      case (bus_r)
        out_stage_pkg::BUS_IDLE: begin
          if (read || write) begin
            bus_r <= out_stage_pkg::BUS_RESP;
          end
        end
        out_stage_pkg::BUS_RESP: begin
          bus_r <= out_stage_pkg::BUS_IDLE;
        end
        default: begin
          bus_r <= out_stage_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // waitrequest is high except in the answering cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((bus_r == out_stage_pkg::BUS_IDLE) && (read || write));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register writes, taken on the first request cycle
  // the word lands at the acceptance edge, one edge before the
  // master sees the answer; the data are held that long anyway
  // gain changes take effect on the very next sample
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_gain_r <= `GAIN_RESET;
      port_b_gain_r <= `GAIN_RESET;
      chan0_i_dc_offset_r <= `OFS_RESET;
      chan0_q_dc_offset_r <= `OFS_RESET;
      chan1_i_dc_offset_r <= `OFS_RESET;
      chan1_q_dc_offset_r <= `OFS_RESET;
      mode_r <= `MODE_RESET;
      stage_cfg_r <= `STAGE_CFG_RESET;
    end else if (wr_hit) begin
      case (address)
        `IDX_PORT_A_GAIN: begin
          port_a_gain_r <= writedata[15:0];
        end
        `IDX_PORT_B_GAIN: begin
          port_b_gain_r <= writedata[15:0];
        end
        `IDX_CHAN0_I_OFS: begin
          chan0_i_dc_offset_r <= writedata[15:0];
        end
        `IDX_CHAN0_Q_OFS: begin
          chan0_q_dc_offset_r <= writedata[15:0];
        end
        `IDX_CHAN1_I_OFS: begin
          chan1_i_dc_offset_r <= writedata[15:0];
        end
        `IDX_CHAN1_Q_OFS: begin
          chan1_q_dc_offset_r <= writedata[15:0];
        end
        `IDX_MODE: begin
          mode_r <= writedata[1:0];
        end
        `IDX_STAGE_CFG: begin
          stage_cfg_r <= writedata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // read mux, unmapped addresses read as zero
  // read data are loaded at the acceptance edge and then hold
  // until the next accepted read, so they stand when sampled
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else if (read && (bus_r == out_stage_pkg::BUS_IDLE)) begin
      case (address)
        `IDX_PORT_A_GAIN: begin
          readdata <= {16'h0000, port_a_gain_r};
        end
        `IDX_PORT_B_GAIN: begin
          readdata <= {16'h0000, port_b_gain_r};
        end
        `IDX_CHAN0_I_OFS: begin
          readdata <= {16'h0000, chan0_i_dc_offset_r};
        end
        `IDX_CHAN0_Q_OFS: begin
          readdata <= {16'h0000, chan0_q_dc_offset_r};
        end
        `IDX_CHAN1_I_OFS: begin
          readdata <= {16'h0000, chan1_i_dc_offset_r};
        end
        `IDX_CHAN1_Q_OFS: begin
          readdata <= {16'h0000, chan1_q_dc_offset_r};
        end
        `IDX_MODE: begin
          readdata <= {30'h00000000, mode_r};
        end
        `IDX_LATENCY: begin
          readdata <= {20'h00000, latency_r};
        end
        `IDX_STAGE_CFG: begin
          readdata <= {16'h0000, stage_cfg_r};
        end
        default: begin
          readdata <= 32'h00000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // latency computed in half samples, then rounded up
  // working in halves keeps every figure a whole number:
  // a disabled stage adds three halves, an enabled stage adds
  // twice the cancel delay plus ninety-five halves, and the
  // fixed part of the path adds thirty-three halves
  // the sum plus one, halved, rounds a half sample upward
  // twelve bits do not hold the worst case of four stages at the
  // largest delay; the sums wrap around at twelve bits
  // the result is registered twice, so a config write shows
  // on the latency port two edges after it lands
  function automatic logic [11:0] calc_latency(input logic [15:0] cfg);
    logic [11:0] half;
    logic [11:0] cdelay;
    half = `LAT_BASE_HALF;
    cdelay = cfg[`CDELAY_MSB:`CDELAY_LSB];
    for (int s = 0; s < NSTAGE; s++) begin
      if (cfg[`STAGE_EN_LSB + s]) begin
        half = 12'(half + 12'(cdelay << 1) + `LAT_EN_HALF);
      end else begin
        half = 12'(half + `LAT_DIS_HALF);
      end
    end
    calc_latency = 12'((half + 12'h001) >> 1);
  endfunction

  always_ff @(posedge clk) begin
    if (rst) begin
      latency_r <= 12'h000;
    end else begin
      latency_r <= calc_latency(stage_cfg_r);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latency_samples <= 12'h000;
    end else begin
      latency_samples <= latency_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // offset selection: real modes use the I offset for both legs
  logic [15:0] ofs_a_q;
  logic [15:0] ofs_b_q;
  logic two_chan;
  logic real_mode;
  logic [15:0] gain_b_sel;
  assign two_chan = mode_r[`MODE_TWO_CHAN_BIT];
  assign real_mode = mode_r[`MODE_REAL_BIT];
  assign ofs_a_q = real_mode ? chan0_i_dc_offset_r : chan0_q_dc_offset_r;
  assign ofs_b_q = real_mode ? chan1_i_dc_offset_r : chan1_q_dc_offset_r;
  // one-channel use leaves port b on channel-0 offsets
  // channel-1 offsets serve port b only in two-channel use; in
  // one-channel real output both ports carry channel-0 samples
  logic [15:0] ofs_b_i_sel;
  logic [15:0] ofs_b_q_sel;
  logic [15:0] ofs_b_q_one;
  assign ofs_b_q_one = real_mode ? chan0_i_dc_offset_r : chan0_q_dc_offset_r;
  assign ofs_b_i_sel = two_chan ? chan1_i_dc_offset_r : chan0_i_dc_offset_r;
  assign ofs_b_q_sel = two_chan ? ofs_b_q : ofs_b_q_one;
  assign gain_b_sel = port_b_gain_r;

  // four lanes: port a on channel 0, port b on channel 1 in two-channel use
  // each lane multiplies, saturates, adds the offset and
  // saturates again, one register per step
  // the lanes outputs are flip-flops, so the ports are too
  gain_offset_lane #(
    .W(W)
  ) lane_a_i (
    .clk(clk),
    .rst(rst),
    .din(in_a_i),
    .gain(port_a_gain_r),
    .offset(chan0_i_dc_offset_r),
    .dout(out_a_i)
  );
  gain_offset_lane #(
    .W(W)
  ) lane_a_q (
    .clk(clk),
    .rst(rst),
    .din(in_a_q),
    .gain(port_a_gain_r),
    .offset(ofs_a_q),
    .dout(out_a_q)
  );
  gain_offset_lane #(
    .W(W)
  ) lane_b_i (
    .clk(clk),
    .rst(rst),
    .din(in_b_i),
    .gain(gain_b_sel),
    .offset(ofs_b_i_sel),
    .dout(out_b_i)
  );
  gain_offset_lane #(
    .W(W)
  ) lane_b_q (
    .clk(clk),
    .rst(rst),
    .din(in_b_q),
    .gain(gain_b_sel),
    .offset(ofs_b_q_sel),
    .dout(out_b_q)
  );

  // valid follows the two-stage lane pipeline
  // a sample taken at one edge leaves two edges later,
  // with out_valid raised in the same cycle as its data
  // the converter side may latch on out_valid alone
  logic valid_d_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      valid_d_r <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      valid_d_r <= in_valid;
      out_valid <= valid_d_r;
    end
  end
endmodule

// file: hdl/out_stage_regs.svh
`ifndef OUT_STAGE_REGS_SVH
`define OUT_STAGE_REGS_SVH
// register indices, byte address is four times the index
`define IDX_PORT_A_GAIN 8'hF3
`define IDX_PORT_B_GAIN 8'hF4
`define IDX_CHAN0_I_OFS 8'hF5
`define IDX_CHAN0_Q_OFS 8'hF6
`define IDX_CHAN1_I_OFS 8'hF7
`define IDX_CHAN1_Q_OFS 8'hF8
`define IDX_MODE 8'hF9
`define IDX_LATENCY 8'hFA
`define IDX_STAGE_CFG 8'hFB
// reset values
`define GAIN_RESET 16'h0000
`define OFS_RESET 16'h0000
`define MODE_RESET 2'h0
`define STAGE_CFG_RESET 16'h0000
// field positions
`define GAIN_SIGN_BIT 15
`define MODE_TWO_CHAN_BIT 0
`define MODE_REAL_BIT 1
`define STAGE_EN_LSB 0
`define STAGE_EN_MSB 3
`define CDELAY_LSB 4
`define CDELAY_MSB 15
// gain has 13 fraction bits (unity code is 1 shl 13)
`define GAIN_FRAC_BITS 13
// latency figures in half samples
`define LAT_DIS_HALF 12'h003
`define LAT_EN_HALF 12'h05F
`define LAT_BASE_HALF 12'h021
`endif

// file: hdl/out_stage_pkg.sv
package out_stage_pkg;
  typedef logic signed [17:0] sample_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RESP = 2'b01
  } bus_state_e;
endpackage

// file: hdl/gain_offset_lane.sv
`timescale 1ns/1ps
`include "out_stage_regs.svh"
// one sample lane: signed gain, saturate, add offset, saturate
module gain_offset_lane #(
  parameter int W = 18
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic signed [W-1:0] din,
  input wire logic [15:0] gain,
  input wire logic [15:0] offset,
  output logic signed [W-1:0] dout
);
  localparam logic signed [W-1:0] MAXV = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};

  function automatic logic signed [W-1:0] sat(input logic signed [W+17:0] v);
    if (v > $signed({{18{1'b0}}, MAXV})) begin
      sat = MAXV;
    end else if (v < $signed({{18{1'b1}}, MINV})) begin
      sat = MINV;
    end else begin
      sat = v[W-1:0];
    end
  endfunction

  logic signed [W+16:0] prod;
  logic signed [W+17:0] scaled;
  logic signed [W-1:0] gained_r;
  logic signed [W+17:0] summed;

  // sign-magnitude gain, magnitude times sample, sign flips result
  assign prod = din * $signed({2'b00, gain[14:0]});
  always_comb begin
    if (gain[`GAIN_SIGN_BIT]) begin
      scaled = -($signed({prod[W+16], prod}) >>> `GAIN_FRAC_BITS);
    end else begin
      scaled = $signed({prod[W+16], prod}) >>> `GAIN_FRAC_BITS;
    end
  end

  // first step: saturate after gain
  always_ff @(posedge clk) begin
    if (rst) begin
      gained_r <= '0;
    end else begin
      gained_r <= sat(scaled);
    end
  end

  // offset aligned to the upper 16 bits of the sample
  assign summed = $signed({{18{gained_r[W-1]}}, gained_r})
    + $signed({{18{offset[15]}}, offset, {(W-16){1'b0}}});

  // second step: saturate after offset; zero gain gives zero output
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= '0;
    end else if (gain[14:0] == 15'h0000) begin
      dout <= '0;
    end else begin
      dout <= sat(summed);
    end
  end
endmodule

// file: testbench/out_stage_sva.sv
`timescale 1ns/1ps
// bus handshake, sample pipeline and zero-gain checks at the stage ports
module out_stage_sva #(
  parameter int W = 18
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic in_valid,
  input wire logic out_valid,
  input wire logic signed [W-1:0] out_a_i,
  input wire logic signed [W-1:0] out_a_q,
  input wire logic signed [W-1:0] out_b_i,
  input wire logic signed [W-1:0] out_b_q,
  input wire logic [11:0] latency_samples
);
  logic [14:0] mag_a_r;
  logic [14:0] mag_b_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadow copies of the gain magnitudes from accepted writes
  always_ff @(posedge clk) begin
    if (rst) begin
      mag_a_r <= 15'h0000;
      mag_b_r <= 15'h0000;
    end else if (write && !waitrequest) begin
      if (address == 8'hF3) mag_a_r <= writedata[14:0];
      if (address == 8'hF4) mag_b_r <= writedata[14:0];
    end
  end
  AST_VALID_PIPE: assert property (##2 (out_valid == $past(in_valid, 2)))
    else $error("out_valid not two cycles after in_valid");
  AST_ACK_ONE: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ACK_BOUND: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
    else $error("access not answered in time");
  AST_NO_SPURIOUS: assert property (!read && !write |=> waitrequest)
    else $error("answer without a request");
  AST_UNMAPPED: assert property (read && !waitrequest && (address < 8'hF3 || address > 8'hFB)
    |-> readdata == 32'h00000000) else $error("unmapped read not zero");
  AST_UPPER_ZERO: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_ZERO_A: assert property (in_valid && !write && mag_a_r == 15'h0000
    |-> ##2 (out_a_i == '0 && out_a_q == '0)) else $error("port a not zero at zero gain");
  AST_ZERO_B: assert property (in_valid && !write && mag_b_r == 15'h0000
    |-> ##2 (out_b_i == '0 && out_b_q == '0)) else $error("port b not zero at zero gain");
  AST_LAT_STABLE: assert property ((!write) [*5] |-> $stable(latency_samples))
    else $error("latency moved without a write");
endmodule
bind output_gain_offset_stage out_stage_sva #(.W(W)) u_out_stage_sva (.clk, .rst, .address,
  .read, .write, .writedata, .readdata, .waitrequest, .in_valid, .out_valid, .out_a_i,
  .out_a_q, .out_b_i, .out_b_q, .latency_samples);

// file: testbench/dac_model.sv
`timescale 1ns/1ps
// converter side: latches every sample word the stage presents
module dac_model #(
  parameter int W = 18
) (
  input wire logic clk,
  input wire logic valid,
  input wire logic signed [W-1:0] a_i,
  input wire logic signed [W-1:0] a_q,
  input wire logic signed [W-1:0] b_i,
  input wire logic signed [W-1:0] b_q,
  output logic signed [W-1:0] cap_a_i,
  output logic signed [W-1:0] cap_a_q,
  output logic signed [W-1:0] cap_b_i,
  output logic signed [W-1:0] cap_b_q
);
  // capture on valid only
  always_ff @(posedge clk) begin
    if (valid) begin
      cap_a_i <= a_i;
      cap_a_q <= a_q;
      cap_b_i <= b_i;
      cap_b_q <= b_q;
    end
  end
endmodule

// file: testbench/output_gain_offset_stage_bench.sv
`timescale 1ns/1ps
module output_gain_offset_stage_bench;
  logic clk, rst, read, write, waitrequest, in_valid, out_valid;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic signed [17:0] in_a_i, in_a_q, in_b_i, in_b_q, out_a_i, out_a_q, out_b_i, out_b_q;
  logic signed [17:0] cap_a_i, cap_a_q, cap_b_i, cap_b_q;
  logic [11:0] latency_samples;
  int err_total, compares;
  output_gain_offset_stage u_output_gain_offset_stage (.clk, .rst, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .in_valid, .in_a_i, .in_a_q, .in_b_i, .in_b_q,
    .out_valid, .out_a_i, .out_a_q, .out_b_i, .out_b_q, .latency_samples);
  dac_model u_dac_model (.clk, .valid(out_valid), .a_i(out_a_i), .a_q(out_a_q),
    .b_i(out_b_i), .b_q(out_b_q), .cap_a_i, .cap_a_q, .cap_b_i, .cap_b_q);
  //////////////////////////////////////////////////////////////////////////////
  // shared helpers
  function automatic logic signed [17:0] sat(input logic signed [35:0] v);
    return (v > 36'sh1FFFF) ? 18'sh1FFFF : (v < -36'sh20000) ? 18'sh20000 : v[17:0];
  endfunction
  function automatic logic signed [17:0] exp_lane(input logic signed [17:0] x,
      input logic [15:0] g, input logic [15:0] o);
    logic signed [35:0] p;
    p = (x * $signed({1'b0, g[14:0]})) >>> 13;
    if (g[15]) p = -p;
    p = sat(p) + ($signed(o) <<< 2);
    return (g[14:0] == 15'h0000) ? 18'sh00000 : sat(p);
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    compares++;
    if (got !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic bus(input logic rd, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    address <= a; read <= rd; write <= !rd; writedata <= {16'hFFFF, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0; write <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
    bus(1'b1, a, 16'h0000);
    chk(what, e, q);
  endtask
  task automatic send(input logic signed [17:0] ai, aq, bi, bq);
    @(posedge clk);
    in_valid <= 1'b1; in_a_i <= ai; in_a_q <= aq; in_b_i <= bi; in_b_q <= bq;
    @(posedge clk);
    in_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic run(input logic [15:0] ga, gb, oi0, oq0, oi1, oq1, input logic [1:0] md,
      input logic signed [17:0] ai, aq, bi, bq);
    logic [15:0] obi, obq;
    obi = md[0] ? oi1 : oi0;
    obq = md[0] ? oq1 : oq0;
    bus(1'b0, 8'hF9, {14'h0000, md}); bus(1'b0, 8'hF3, ga); bus(1'b0, 8'hF4, gb);
    bus(1'b0, 8'hF5, oi0); bus(1'b0, 8'hF6, oq0); bus(1'b0, 8'hF7, oi1); bus(1'b0, 8'hF8, oq1);
    send(ai, aq, bi, bq);
    chk("out_a_i", exp_lane(ai, ga, oi0), cap_a_i);
    chk("out_a_q", exp_lane(aq, ga, md[1] ? oi0 : oq0), cap_a_q);
    chk("out_b_i", exp_lane(bi, gb, obi), cap_b_i);
    chk("out_b_q", exp_lane(bq, gb, md[1] ? obi : obq), cap_b_q);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    for (int i = 8'hF3; i <= 8'hFB; i++) if (i != 8'hFA) rdc("reg", i[7:0], 32'h0);
    rdc("latency", 8'hFA, 32'h17);
    chk("latency_samples", 32'h17, {20'h0, latency_samples});
    rdc("unmapped", 8'h10, 32'h0);
    send(18'sh003E8, 18'sh20000, 18'sh1FFFF, -18'sh00010);
    chk("zero out", 32'h0, {14'h0, cap_a_i | cap_a_q | cap_b_i | cap_b_q});
  endtask
  task automatic t_gain();
    run(16'h2000, 16'h4000, 16'h0001, 16'hFFFE, 16'h0003, 16'h0004, 2'h1, 18'sh003E8,
      -18'sh003E8, 18'sh001F4, -18'sh001F4);
    rdc("port_b_gain", 8'hF4, 32'h4000);
    run(16'h3000, 16'hA000, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 2'h1, 18'sh003E8,
      18'sh00100, 18'sh001F4, -18'sh00200);
    run(16'h7FFF, 16'hFFFF, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000, 2'h1, 18'sh1FFFF,
      18'sh20000, 18'sh1FFFF, 18'sh20000);
    run(16'h8000, 16'h0000, 16'h0010, 16'h0020, 16'h0030, 16'h0040, 2'h1, 18'sh00400,
      18'sh00400, 18'sh00400, 18'sh00400);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) run(16'h2000, 16'h2000, 16'h0010, 16'h0020, 16'h0030,
      16'h0040, m[1:0], 18'sh00100, 18'sh00200, 18'sh00300, 18'sh00400);
  endtask
  task automatic t_latency();
    logic [15:0] cfg [3] = '{16'h00A1, 16'h000F, 16'h0023};
    logic [11:0] lat [3] = '{12'h04F, 12'h0CF, 12'h077};
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 8'hFB, cfg[i]);
      rdc("latency", 8'hFA, {20'h0, lat[i]});
      chk("latency_samples", {20'h0, lat[i]}, {20'h0, latency_samples});
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rst = 1'b1; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
    in_valid = 1'b0; in_a_i = '0; in_a_q = '0; in_b_i = '0; in_b_q = '0;
    err_total = 0; compares = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_gain();
    t_modes();
    t_latency();
    report_and_stop();
  end
endmodule
